//--- hdl/tcu_pkg.sv
/*
 * Package of the eight-bit timer-counter: register offsets, field positions,
 * reset values, waveform modes and prescaler figures.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package tcu_pkg;

    localparam logic [7:0] TCU_OFF_CONTROL = 8'h00;
    localparam logic [7:0] TCU_OFF_COUNTER = 8'h04;
    localparam logic [7:0] TCU_OFF_COMPARE = 8'h08;
    localparam logic [7:0] TCU_OFF_FLAGS = 8'h0C;
    localparam logic [7:0] TCU_OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] TCU_OFF_PORT = 8'h14;

    // Control word fields.
    localparam int TCU_CS_LSB = 0;
    localparam int TCU_WGM_LSB = 3;
    localparam int TCU_COM_LSB = 5;
    localparam int TCU_FOC_BIT = 7;

    // Flag and enable bit positions.
    localparam int TCU_OVF_BIT = 0;
    localparam int TCU_CMP_BIT = 1;

    // Port word bits.
    localparam int TCU_DIR_BIT = 0;
    localparam int TCU_PVAL_BIT = 1;

    localparam logic [7:0] TCU_RST_BYTE = 8'h00;
    localparam logic [7:0] TCU_MAX = 8'hFF;
    localparam logic [7:0] TCU_BOTTOM = 8'h00;

    typedef enum logic [1:0] {
        TCU_WGM_NORMAL = 2'b00,
        TCU_WGM_PCPWM = 2'b01,
        TCU_WGM_CTC = 2'b10,
        TCU_WGM_FAST = 2'b11
    } tcu_wgm_type;

    typedef enum logic [1:0] {
        TCU_COM_OFF = 2'b00,
        TCU_COM_TOGGLE = 2'b01,
        TCU_COM_CLEAR = 2'b10,
        TCU_COM_SET = 2'b11
    } tcu_com_type;

    typedef enum logic [2:0] {
        TCU_CS_STOP = 3'b000,
        TCU_CS_DIV1 = 3'b001,
        TCU_CS_DIV8 = 3'b010,
        TCU_CS_DIV64 = 3'b011,
        TCU_CS_DIV256 = 3'b100,
        TCU_CS_DIV1024 = 3'b101,
        TCU_CS_EXT_FALL = 3'b110,
        TCU_CS_EXT_RISE = 3'b111
    } tcu_cs_type;

    localparam int TCU_PRESCALE_W = 10;

endpackage

//--- hdl/tcu_timer.sv
/*
 * Eight-bit up/down timer-counter with one compare channel, its compare
 * output pin logic, Normal, CTC, fast PWM and phase correct PWM sequences,
 * and an APB register slave with zero wait states.
 * Assumes pclk at 25 MHz, an asynchronous event pin, and a processor core
 * on pclk that supplies the global interrupt enable and service acknowledges.
 */
// Overview of operation
// - Stopped when source zero; step per tick
// - Counter readable and writable at any time
// - Processor counter write beats counting
// - Provide top and bottom indications
// - Compare match sets flag next tick
// - Compare request needs flag, enable, global
// - Flag cleared by service or written one
// - Compare buffered in PWM modes only
// - Accesses reach buffer when buffering active
// - Force strobe updates output in non-PWM modes, no flag
// - Counter write blocks next tick's match
// - Output select unbuffered, next match effect
// - Output register resets zero, kept
// - Nonzero select overrides port value
// - Pin shows value only when output
// - Select zero leaves output unchanged
// - Mode sets sequence, select sets action
// - Normal mode always increments, wraps
// - Overflow flag set when counter wraps, or on reaching bottom in mode one
// - Mode two clears on compare
// - Mode three single-slope fast PWM
// - Mode one dual-slope phase correct
`timescale 1ns/1ps

module tcu_timer
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic event_pin,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    output logic compare_irq_req,
    output logic overflow_irq_req,
    output logic compare_output,
    output logic compare_output_oe_n
);
    import tcu_pkg::*;

    logic [2:0] clock_source_select_r;
    logic [1:0] waveform_mode_select_r;
    logic [1:0] compare_output_select_r;
    logic [7:0] counter_value_r;
    logic [7:0] compare_value_r;
    logic [7:0] compare_buffer_r;
    logic compare_match_flag_r;
    logic overflow_flag_r;
    logic compare_irq_enable_r;
    logic overflow_irq_enable_r;
    logic pin_direction_bit_r;
    logic port_value_r;
    logic count_down_r;
    logic match_block_r;
    logic oc_r;
    logic [TCU_PRESCALE_W-1:0] prescale_r;
    logic ev_s1_r;
    logic ev_s2_r;
    logic ev_s3_r;
    logic ev_level_r;
    logic ev_rise_r;
    logic ev_fall_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic compare_irq_req_r;
    logic overflow_irq_req_r;
    logic pin_out_r;
    logic pin_oe_n_r;

    logic timer_tick;
    logic wr_access;
    logic wr_control;
    logic wr_counter;
    logic wr_compare;
    logic wr_flags;
    logic force_now;
    logic pwm_mode;
    logic at_top;
    logic at_bottom;
    logic comparator_eq;
    logic live_match;
    logic overflow_event;
    logic [7:0] counter_nxt;
    logic count_down_nxt;
    logic oc_nxt;
    logic [31:0] read_word;
    logic addr_ok;

    // True when the low bits of the free-running prescaler are all ones.
    function automatic logic prescale_hit(input logic [TCU_PRESCALE_W-1:0] cnt,
                                          input int bits);
        logic [TCU_PRESCALE_W-1:0] mask;
        mask = TCU_PRESCALE_W'((1 << bits) - 1);
        return (cnt & mask) == mask;
    endfunction

    // Compare output action for set, clear or toggle on a match.
    function automatic logic match_action(input logic cur, input logic [1:0] sel);
        logic res;
        res = cur;
        unique case (sel)
            TCU_COM_OFF: res = cur;
            TCU_COM_TOGGLE: res = ~cur;
            TCU_COM_CLEAR: res = 1'b0;
            TCU_COM_SET: res = 1'b1;
        endcase
        return res;
    endfunction

    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
        return a == off;
    endfunction

    // Prescaler; it runs free so that any division ratio is available at once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prescale_r <= '0;
        else
            prescale_r <= prescale_r + 1'b1;
    end

    // Event pin: three stages, and a change counts once stages two and three agree.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ev_s1_r <= 1'b0;
            ev_s2_r <= 1'b0;
            ev_s3_r <= 1'b0;
            ev_level_r <= 1'b0;
            ev_rise_r <= 1'b0;
            ev_fall_r <= 1'b0;
        end
        else
        begin
            ev_s1_r <= event_pin;
            ev_s2_r <= ev_s1_r;
            ev_s3_r <= ev_s2_r;
            ev_rise_r <= 1'b0;
            ev_fall_r <= 1'b0;
            if (ev_s2_r == ev_s3_r && ev_s3_r != ev_level_r)
            begin
                ev_level_r <= ev_s3_r;
                ev_rise_r <= ev_s3_r;
                ev_fall_r <= ~ev_s3_r;
            end
        end
    end

    always_comb
    begin
        timer_tick = 1'b0;
        unique case (clock_source_select_r)
            TCU_CS_STOP: timer_tick = 1'b0;
            TCU_CS_DIV1: timer_tick = 1'b1;
            TCU_CS_DIV8: timer_tick = prescale_hit(prescale_r, 3);
            TCU_CS_DIV64: timer_tick = prescale_hit(prescale_r, 6);
            TCU_CS_DIV256: timer_tick = prescale_hit(prescale_r, 8);
            TCU_CS_DIV1024: timer_tick = prescale_hit(prescale_r, 10);
            TCU_CS_EXT_FALL: timer_tick = ev_fall_r;
            TCU_CS_EXT_RISE: timer_tick = ev_rise_r;
        endcase
    end

    assign wr_access = psel && penable && pready_r && pwrite;
    assign wr_control = wr_access && addr_is(paddr, TCU_OFF_CONTROL);
    assign wr_counter = wr_access && addr_is(paddr, TCU_OFF_COUNTER);
    assign wr_compare = wr_access && addr_is(paddr, TCU_OFF_COMPARE);
    assign wr_flags = wr_access && addr_is(paddr, TCU_OFF_FLAGS);
    assign pwm_mode = waveform_mode_select_r == TCU_WGM_PCPWM ||
                      waveform_mode_select_r == TCU_WGM_FAST;
    assign force_now = wr_control && pwdata[TCU_FOC_BIT] && !pwm_mode;

    assign at_bottom = counter_value_r == TCU_BOTTOM;
    assign at_top = (waveform_mode_select_r == TCU_WGM_CTC) ?
                    (counter_value_r == compare_value_r) : (counter_value_r == TCU_MAX);

    assign comparator_eq = counter_value_r == compare_value_r;
    assign live_match = timer_tick && comparator_eq && !match_block_r;

    always_comb
    begin
        counter_nxt = counter_value_r;
        count_down_nxt = count_down_r;
        overflow_event = 1'b0;
        unique case (waveform_mode_select_r)
            TCU_WGM_NORMAL:
            begin
                counter_nxt = counter_value_r + 1'b1;
                overflow_event = counter_value_r == TCU_MAX;
            end
            TCU_WGM_CTC:
            begin
                counter_nxt = comparator_eq ? TCU_BOTTOM : counter_value_r + 1'b1;
                overflow_event = counter_value_r == TCU_MAX;
            end
            TCU_WGM_FAST:
            begin
                counter_nxt = counter_value_r + 1'b1;
                overflow_event = counter_value_r == TCU_MAX;
            end
            TCU_WGM_PCPWM:
            begin
                if (!count_down_r)
                begin
                    if (counter_value_r == TCU_MAX)
                    begin
                        count_down_nxt = 1'b1;
                        counter_nxt = counter_value_r - 1'b1;
                    end
                    else
                        counter_nxt = counter_value_r + 1'b1;
                end
                else if (at_bottom)
                begin
                    count_down_nxt = 1'b0;
                    counter_nxt = counter_value_r + 1'b1;
                end
                else
                begin
                    counter_nxt = counter_value_r - 1'b1;
                    overflow_event = counter_value_r == 8'h01;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            counter_value_r <= TCU_RST_BYTE;
            count_down_r <= 1'b0;
        end
        else if (wr_counter)
            counter_value_r <= pwdata[7:0];
        else if (timer_tick)
        begin
            counter_value_r <= counter_nxt;
            count_down_r <= count_down_nxt;
        end
        else if (waveform_mode_select_r != TCU_WGM_PCPWM)
            count_down_r <= 1'b0;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            match_block_r <= 1'b0;
        else if (wr_counter)
            match_block_r <= 1'b1;
        else if (timer_tick)
            match_block_r <= 1'b0;
    end

    // buffered transfer at top only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_buffer_r <= TCU_RST_BYTE;
            compare_value_r <= TCU_RST_BYTE;
        end
        else
        begin
            if (wr_compare)
                compare_buffer_r <= pwdata[7:0];
            if (wr_compare && !pwm_mode)
                compare_value_r <= pwdata[7:0];
            else if (pwm_mode && timer_tick && at_top)
                compare_value_r <= compare_buffer_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            clock_source_select_r <= TCU_CS_STOP;
            waveform_mode_select_r <= TCU_WGM_NORMAL;
            compare_output_select_r <= TCU_COM_OFF;
        end
        else if (wr_control)
        begin
            clock_source_select_r <= pwdata[TCU_CS_LSB +: 3];
            waveform_mode_select_r <= pwdata[TCU_WGM_LSB +: 2];
            compare_output_select_r <= pwdata[TCU_COM_LSB +: 2];
        end
    end

    // Waveform generator; in fast PWM the bottom action follows the match so
    // that a compare value at MAX gives a constant level.
    always_comb
    begin
        oc_nxt = oc_r;
        if (live_match)
        begin
            unique case (waveform_mode_select_r)
                TCU_WGM_NORMAL, TCU_WGM_CTC:
                    oc_nxt = match_action(oc_r, compare_output_select_r);
                TCU_WGM_FAST:
                    oc_nxt = match_action(oc_r, compare_output_select_r);
                TCU_WGM_PCPWM:
                    if (compare_output_select_r[1])
                        oc_nxt = compare_output_select_r[0] ^ count_down_r;
            endcase
        end
        if (timer_tick && waveform_mode_select_r == TCU_WGM_FAST &&
            counter_value_r == TCU_MAX && compare_output_select_r[1])
            oc_nxt = ~compare_output_select_r[0];
    end

    // reset to zero, kept across modes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            oc_r <= 1'b0;
        else if (force_now)
            oc_r <= match_action(oc_r, pwdata[TCU_COM_LSB +: 2]);
        else
            oc_r <= oc_nxt;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_match_flag_r <= 1'b0;
            overflow_flag_r <= 1'b0;
        end
        else
        begin
            if (live_match)
                compare_match_flag_r <= 1'b1;
            else if (compare_irq_ack || (wr_flags && pwdata[TCU_CMP_BIT]))
                compare_match_flag_r <= 1'b0;
            if (timer_tick && !wr_counter && overflow_event)
                overflow_flag_r <= 1'b1;
            else if (overflow_irq_ack || (wr_flags && pwdata[TCU_OVF_BIT]))
                overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_irq_req_r <= 1'b0;
            overflow_irq_req_r <= 1'b0;
        end
        else
        begin
            compare_irq_req_r <= compare_match_flag_r && compare_irq_enable_r &&
                                 global_irq_enable && !compare_irq_ack;
            overflow_irq_req_r <= overflow_flag_r && overflow_irq_enable_r &&
                                  global_irq_enable && !overflow_irq_ack;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            compare_irq_enable_r <= 1'b0;
            overflow_irq_enable_r <= 1'b0;
            pin_direction_bit_r <= 1'b0;
            port_value_r <= 1'b0;
        end
        else
        begin
            if (wr_access && addr_is(paddr, TCU_OFF_IRQ_EN))
            begin
                compare_irq_enable_r <= pwdata[TCU_CMP_BIT];
                overflow_irq_enable_r <= pwdata[TCU_OVF_BIT];
            end
            if (wr_access && addr_is(paddr, TCU_OFF_PORT))
            begin
                pin_direction_bit_r <= pwdata[TCU_DIR_BIT];
                port_value_r <= pwdata[TCU_PVAL_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin_out_r <= 1'b0;
            pin_oe_n_r <= 1'b1;
        end
        else
        begin
            pin_out_r <= (compare_output_select_r != TCU_COM_OFF) ? oc_r : port_value_r;
            pin_oe_n_r <= ~pin_direction_bit_r;
        end
    end

    // The force strobe always reads back as zero.
    always_comb
    begin
        read_word = '0;
        addr_ok = 1'b1;
        unique case (paddr)
            TCU_OFF_CONTROL:
            begin
                read_word[TCU_CS_LSB +: 3] = clock_source_select_r;
                read_word[TCU_WGM_LSB +: 2] = waveform_mode_select_r;
                read_word[TCU_COM_LSB +: 2] = compare_output_select_r;
            end
            TCU_OFF_COUNTER: read_word[7:0] = counter_value_r;
            TCU_OFF_COMPARE: read_word[7:0] = pwm_mode ? compare_buffer_r : compare_value_r;
            TCU_OFF_FLAGS:
            begin
                read_word[TCU_CMP_BIT] = compare_match_flag_r;
                read_word[TCU_OVF_BIT] = overflow_flag_r;
            end
            TCU_OFF_IRQ_EN:
            begin
                read_word[TCU_CMP_BIT] = compare_irq_enable_r;
                read_word[TCU_OVF_BIT] = overflow_irq_enable_r;
            end
            TCU_OFF_PORT:
            begin
                read_word[TCU_DIR_BIT] = pin_direction_bit_r;
                read_word[TCU_PVAL_BIT] = port_value_r;
            end
            default: addr_ok = 1'b0;
        endcase
    end

    // Answer is prepared in the setup cycle so the access phase ends at once.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else if (psel && !penable)
        begin
            prdata_r <= pwrite ? 32'h0000_0000 : read_word;
            pready_r <= 1'b1;
            pslverr_r <= ~addr_ok;
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign compare_irq_req = compare_irq_req_r;
    assign overflow_irq_req = overflow_irq_req_r;
    assign compare_output = pin_out_r;
    assign compare_output_oe_n = pin_oe_n_r;

endmodule

//--- bench/tcu_timer_checker.sv
/* Port checker for the timer-counter, bound into tcu_timer.
   Assumes the zero-wait APB slave and the register layout of tcu_pkg. */
`timescale 1ns/1ps
module tcu_timer_checker
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic event_pin,
    input wire logic global_irq_enable,
    input wire logic compare_irq_ack,
    input wire logic overflow_irq_ack,
    input wire logic compare_irq_req,
    input wire logic overflow_irq_req,
    input wire logic compare_output,
    input wire logic compare_output_oe_n
);
    import tcu_pkg::*;
    logic wr_acc;
    logic [1:0] com_r;
    logic [2:0] cs_r;
    logic dir_r;
    logic pval_r;
    // Shadow copies of the written words, so the pin and acknowledge checks know the setting.
    assign wr_acc = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            com_r <= 2'h0;
            cs_r <= 3'h0;
        end
        else if (wr_acc && paddr == TCU_OFF_CONTROL)
        begin
            com_r <= pwdata[6:5];
            cs_r <= pwdata[2:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dir_r <= 1'b0;
            pval_r <= 1'b0;
        end
        else if (wr_acc && paddr == TCU_OFF_PORT)
        begin
            dir_r <= pwdata[TCU_DIR_BIT];
            pval_r <= pwdata[TCU_PVAL_BIT];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_ready_next: assert property (psel && !penable |=> pready)
        else $error("ready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_unmapped_err: assert property (psel && !penable && paddr > TCU_OFF_PORT |=> pslverr)
        else $error("no error on unmapped address");
    chk_mapped_ok: assert property (psel && !penable && paddr <= TCU_OFF_PORT &&
        paddr[1:0] == 2'h0 |=> !pslverr) else $error("error on mapped address");
    chk_global_gate: assert property (!global_irq_enable |=>
        !compare_irq_req && !overflow_irq_req) else $error("request without global enable");
    chk_ack_clears: assert property (compare_irq_ack && cs_r == 3'h0 |=> ##1
        !compare_irq_req) else $error("compare request not cleared by ack");
    chk_oe_dir: assert property ($stable(dir_r) |-> compare_output_oe_n == !dir_r)
        else $error("pin enable differs from direction bit");
    chk_port_pass: assert property ($stable(pval_r) && $stable(com_r) && com_r == 2'h0
        |-> compare_output == pval_r) else $error("port value not on pin");
endmodule

bind tcu_timer tcu_timer_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .event_pin, .global_irq_enable, .compare_irq_ack,
    .overflow_irq_ack, .compare_irq_req, .overflow_irq_req, .compare_output,
    .compare_output_oe_n);

//--- bench/test_tcu_timer.sv
/* Directed bench for the timer-counter: APB master tasks and scenarios.
   Assumes tcu_timer with a zero-wait APB slave; event_pin gives exact ticks. */
`timescale 1ns/1ps
module test_tcu_timer;
    import tcu_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic event_pin = 1'b0;
    logic global_irq_enable = 1'b0;
    logic compare_irq_ack = 1'b0;
    logic overflow_irq_ack = 1'b0;
    logic compare_irq_req;
    logic overflow_irq_req;
    logic compare_output;
    logic compare_output_oe_n;
    logic [31:0] rdata;
    logic rerr;
    int n_errors = 0;
    int comparisons = 0;

    always #20 pclk = ~pclk;

    tcu_timer DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .event_pin, .global_irq_enable, .compare_irq_ack,
        .overflow_irq_ack, .compare_irq_req, .overflow_irq_req, .compare_output,
        .compare_output_oe_n);

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR at %0t: got 0x%0h expected 0x%0h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // The request is held until pready is seen high, so a slow answer is still met.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(rdata, exp);
    endtask

    function automatic logic [31:0] cw(logic [2:0] cs, logic [1:0] wgm, logic [1:0] com,
        logic foc);
        return {24'h0, foc, com, wgm, cs};
    endfunction

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge pclk);
            event_pin <= 1'b1;
            repeat (6) @(posedge pclk);
            event_pin <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask

    task automatic pin(input logic o, input logic oe_n);
        repeat (3) @(posedge pclk);
        check({31'h0, compare_output}, {31'h0, o});
        check({31'h0, compare_output_oe_n}, {31'h0, oe_n});
    endtask

    task automatic t_reset;
        for (int i = 0; i < 6; i++)
            rd(8'(i * 4), 32'h0);
        rd(8'h18, 32'h0);
        check({31'h0, rerr}, 32'h1);
        pin(1'b0, 1'b1);
        $display("test reset done");
    endtask

    task automatic t_normal;
        wr(TCU_OFF_COUNTER, 32'hFE);
        tick(2);
        rd(TCU_OFF_COUNTER, 32'hFE);
        wr(TCU_OFF_CONTROL, cw(3'h7, 2'h0, 2'h0, 1'b0));
        tick(3);
        rd(TCU_OFF_COUNTER, 32'h01);
        rd(TCU_OFF_FLAGS, 32'h3);
        wr(TCU_OFF_IRQ_EN, 32'h1);
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        check({31'h0, overflow_irq_req}, 32'h1);
        global_irq_enable <= 1'b0;
        wr(TCU_OFF_FLAGS, 32'h3);
        rd(TCU_OFF_FLAGS, 32'h0);
        $display("test normal done");
    endtask

    task automatic t_compare;
        wr(TCU_OFF_COMPARE, 32'h10);
        wr(TCU_OFF_COUNTER, 32'h10);
        tick(1);
        rd(TCU_OFF_FLAGS, 32'h0);
        wr(TCU_OFF_COUNTER, 32'h0E);
        tick(2);
        rd(TCU_OFF_FLAGS, 32'h0);
        tick(1);
        rd(TCU_OFF_FLAGS, 32'h2);
        wr(TCU_OFF_IRQ_EN, 32'h2);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h0, 1'b0));
        global_irq_enable <= 1'b1;
        repeat (3) @(posedge pclk);
        check({31'h0, compare_irq_req}, 32'h1);
        compare_irq_ack <= 1'b1;
        @(posedge pclk);
        compare_irq_ack <= 1'b0;
        rd(TCU_OFF_FLAGS, 32'h0);
        check({31'h0, compare_irq_req}, 32'h0);
        global_irq_enable <= 1'b0;
        $display("test compare done");
    endtask

    task automatic t_output;
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h2, 1'b1));
        wr(TCU_OFF_PORT, 32'h3);
        pin(1'b0, 1'b0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h0, 1'b0));
        pin(1'b1, 1'b0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h3, 1'b1));
        pin(1'b1, 1'b0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h2, 1'b1));
        pin(1'b0, 1'b0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h1, 1'b1));
        pin(1'b1, 1'b0);
        wr(TCU_OFF_PORT, 32'h1);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h0, 1'b1));
        pin(1'b0, 1'b0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h2, 2'h0, 1'b0));
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h2, 1'b0));
        pin(1'b1, 1'b0);
        rd(TCU_OFF_FLAGS, 32'h0);
        rd(TCU_OFF_COUNTER, 32'h11);
        wr(TCU_OFF_PORT, 32'h0);
        pin(1'b1, 1'b1);
        // A reset in mid-run must clear the compare output register, which is set here.
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h2, 1'b0));
        pin(1'b0, 1'b1);
        $display("test output done");
    endtask

    task automatic t_modes;
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h2, 2'h0, 1'b0));
        wr(TCU_OFF_COMPARE, 32'h3);
        rd(TCU_OFF_COMPARE, 32'h3);
        wr(TCU_OFF_COUNTER, 32'h0);
        wr(TCU_OFF_CONTROL, cw(3'h7, 2'h2, 2'h0, 1'b0));
        tick(4);
        rd(TCU_OFF_COUNTER, 32'h0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h0, 1'b0));
        wr(TCU_OFF_COMPARE, 32'h5);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h3, 2'h0, 1'b0));
        wr(TCU_OFF_COMPARE, 32'h80);
        wr(TCU_OFF_COUNTER, 32'h4);
        wr(TCU_OFF_FLAGS, 32'h3);
        wr(TCU_OFF_CONTROL, cw(3'h7, 2'h3, 2'h0, 1'b0));
        tick(2);
        rd(TCU_OFF_FLAGS, 32'h2);
        rd(TCU_OFF_COMPARE, 32'h80);
        wr(TCU_OFF_COUNTER, 32'hFE);
        tick(2);
        rd(TCU_OFF_COUNTER, 32'h0);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h1, 2'h0, 1'b0));
        wr(TCU_OFF_COUNTER, 32'hFE);
        wr(TCU_OFF_CONTROL, cw(3'h7, 2'h1, 2'h0, 1'b0));
        tick(3);
        rd(TCU_OFF_COUNTER, 32'hFD);
        wr(TCU_OFF_CONTROL, cw(3'h6, 2'h0, 2'h0, 1'b0));
        wr(TCU_OFF_COUNTER, 32'h0);
        tick(2);
        rd(TCU_OFF_COUNTER, 32'h2);
        // The counter then steps on every pclk, one step before the read samples it.
        wr(TCU_OFF_CONTROL, cw(3'h1, 2'h0, 2'h0, 1'b0));
        wr(TCU_OFF_COUNTER, 32'h40);
        rd(TCU_OFF_COUNTER, 32'h41);
        wr(TCU_OFF_CONTROL, cw(3'h0, 2'h0, 2'h0, 1'b0));
        $display("test modes done");
    endtask

    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_normal;
        t_compare;
        t_output;
        t_modes;
        complete_run;
    end

    initial
    begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        complete_run;
    end
endmodule
